/* pio_defs.vh */
// Constants for the parallel port block: register indices, fields, resets.
// Assumes inclusion by the design and its bench; byte address is 4 x index.
`ifndef PIO_DEFS_VH
`define PIO_DEFS_VH

// ****************************************
// Register indices
// ****************************************
`define PIO_IDX_A_DATA     6'h00
`define PIO_IDX_A_DIR      6'h01
`define PIO_IDX_B_DIR      6'h02
`define PIO_IDX_B_DATA     6'h04
`define PIO_IDX_C_DATA     6'h05
`define PIO_IDX_C_DIR      6'h06
`define PIO_IDX_D_DIR      6'h09
`define PIO_IDX_PA_CTRL    6'h0A
`define PIO_IDX_CAPCMP     6'h0B
`define PIO_IDX_PULLUP     6'h0C
`define PIO_IDX_STATUS     6'h0D

// ****************************************
// Fields and reset values
// ****************************************
`define PIO_SEL_BIT        2
`define PIO_PU_B_BIT       0
`define PIO_PU_C_BIT       1
`define PIO_DIR_RST        8'h00
`define PIO_C_DATA_RST     8'h00
`define PIO_CAPCMP_RST     16'hFFFF
`define PIO_D_DIR_MASK     8'h3F
`define PIO_LINES_MAX      6'h3E
`define PIO_LINES_BUS      6'h10

`endif

/* pio_ports.v */
// Parallel ports A to D: direction, data latches, pin muxing, APB slave.
// Assumes timer, SPI and expanded bus logic on pclk; pins are asynchronous.
`timescale 1ns/1ns
`include "pio_defs.vh"

module pio_ports
(
	// Clock and reset
	input  wire        pclk,
	input  wire        presetn,
	// APB slave
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [7:0]  paddr,
	input  wire [31:0] pwdata,
	input  wire [3:0]  pstrb,
	output wire        pready,
	output reg  [31:0] prdata,
	output reg         pslverr,
	// Mode strap
	input  wire        strap_expanded,
	// Port A pins
	input  wire [7:0]  pa_in,
	output reg  [7:0]  pa_out,
	output reg  [7:0]  pa_oe_n,
	// Port B pins
	input  wire [7:0]  pb_in,
	output reg  [7:0]  pb_out,
	output reg  [7:0]  pb_oe_n,
	output reg         pb_pullup_en,
	// Port C pins
	input  wire [7:0]  pc_in,
	output reg  [7:0]  pc_out,
	output reg  [7:0]  pc_oe_n,
	output reg         pc_pullup_en,
	// Port D bit 5 pin
	input  wire        pd5_in,
	output reg         pd5_oe_n,
	// Timer side
	input  wire [7:0]  timer_drive,
	input  wire [7:0]  timer_level,
	input  wire        capture_load,
	input  wire [15:0] capture_value,
	output wire        capture_compare_select,
	output wire [15:0] shared_capture_compare_reg,
	output wire        fourth_input_capture,
	output wire        pulse_accum_input,
	// SPI side
	input  wire        spi_master,
	output wire        spi_error_detect,
	output wire [5:0]  fourth_port_dir_bits,
	// Expanded bus side
	input  wire [7:0]  high_address,
	input  wire [7:0]  bus_data_out,
	input  wire        bus_data_drive,
	output wire [7:0]  bus_data_in,
	// Mode status
	output reg         expanded_mode,
	output reg  [5:0]  lines_available
);

// ****************************************
// Functions
// ****************************************
// Reads: input bits show the pin, output bits the latch
function [7:0] port_view;
	input [7:0] dir;
	input [7:0] latch;
	input [7:0] pin;
	begin
		port_view = (dir & latch) | (~dir & pin);
	end
endfunction

// ****************************************
// Pin synchronisers
// ****************************************
reg  [7:0]  pa_meta;
reg  [7:0]  pa_sync;
reg  [7:0]  pb_meta;
reg  [7:0]  pb_sync;
reg  [7:0]  pc_meta;
reg  [7:0]  pc_sync;
reg         pd5_meta;
reg         pd5_sync;
reg         strap_meta;
reg         strap_sync;

always @(posedge pclk or negedge presetn)
begin
	if (!presetn)
	begin
		pa_meta    <= 8'h00;
		pa_sync    <= 8'h00;
		pb_meta    <= 8'h00;
		pb_sync    <= 8'h00;
		pc_meta    <= 8'h00;
		pc_sync    <= 8'h00;
		pd5_meta   <= 1'b0;
		pd5_sync   <= 1'b0;
		strap_meta <= 1'b0;
		strap_sync <= 1'b0;
	end
	else
	begin
		pa_meta    <= pa_in;
		pa_sync    <= pa_meta;
		pb_meta    <= pb_in;
		pb_sync    <= pb_meta;
		pc_meta    <= pc_in;
		pc_sync    <= pc_meta;
		pd5_meta   <= pd5_in;
		pd5_sync   <= pd5_meta;
		strap_meta <= strap_expanded;
		strap_sync <= strap_meta;
	end
end

// ****************************************
// Registers
// ****************************************
reg  [7:0]  a_latch;
reg  [7:0]  first_port_dir_bits;
reg  [7:0]  b_latch;
reg  [7:0]  second_port_dir_bits;
reg  [7:0]  third_port_data;
reg  [7:0]  third_port_dir_bits;
reg  [5:0]  d_dir;
reg         sel_capture;
reg  [15:0] capcmp;
reg  [1:0]  pullup_sel;
reg  [1:0]  init_count;

wire        setup_phase = psel & ~penable;
wire        wr_access   = psel & penable & pwrite;
wire [5:0]  idx         = paddr[7:2];
wire        init_busy   = (init_count != 2'h0);
wire        wr_lo       = wr_access & pstrb[0];
wire        wr_hi       = wr_access & pstrb[1];

assign pready                     = 1'b1;
assign capture_compare_select     = sel_capture;
assign shared_capture_compare_reg = capcmp;
assign fourth_port_dir_bits       = d_dir;

// Strap and pin levels reach the latches after two sync stages
always @(posedge pclk or negedge presetn)
begin
	if (!presetn)
	begin
		init_count           <= 2'h3;
		expanded_mode        <= 1'b0;
		lines_available      <= `PIO_LINES_MAX;
		a_latch              <= 8'h00;
		b_latch              <= 8'h00;
		first_port_dir_bits  <= `PIO_DIR_RST;
		second_port_dir_bits <= `PIO_DIR_RST;
		third_port_dir_bits  <= `PIO_DIR_RST;
		third_port_data      <= `PIO_C_DATA_RST;
		d_dir                <= 6'h00;
		sel_capture          <= 1'b0;
		capcmp               <= `PIO_CAPCMP_RST;
		pullup_sel           <= 2'h0;
	end
	else if (init_busy)
	begin
		init_count <= init_count - 2'h1;
		if (init_count == 2'h1)
		begin
			// A and B latches follow the pins as they stood at the first edge after reset
			a_latch         <= pa_sync;
			b_latch         <= pb_sync;
			expanded_mode   <= strap_sync;
			lines_available <= strap_sync ?
				(`PIO_LINES_MAX - `PIO_LINES_BUS) : `PIO_LINES_MAX;
		end
	end
	else
	begin
		if (wr_lo)
		begin
			case (idx)
			`PIO_IDX_A_DATA: a_latch <= pwdata[7:0];
			`PIO_IDX_A_DIR:  first_port_dir_bits <= pwdata[7:0];
			`PIO_IDX_B_DIR:  second_port_dir_bits <= pwdata[7:0];
			`PIO_IDX_B_DATA:
				if (!expanded_mode)
					b_latch <= pwdata[7:0];
			`PIO_IDX_C_DATA:
				if (!expanded_mode)
					third_port_data <= pwdata[7:0];
			`PIO_IDX_C_DIR:  third_port_dir_bits <= pwdata[7:0];
			`PIO_IDX_D_DIR:  d_dir <= pwdata[5:0];
			`PIO_IDX_PA_CTRL: sel_capture <= pwdata[`PIO_SEL_BIT];
			`PIO_IDX_PULLUP: pullup_sel <= pwdata[1:0];
			default: ;
			endcase
		end
		// Capture hardware owns the register while selected
		if (sel_capture && capture_load)
			capcmp <= capture_value;
		else if (!sel_capture && idx == `PIO_IDX_CAPCMP)
		begin
			if (wr_lo)
				capcmp[7:0] <= pwdata[7:0];
			if (wr_hi)
				capcmp[15:8] <= pwdata[15:8];
		end
	end
end

// ****************************************
// Pin drive
// ****************************************
reg  [7:0]  a_timer;

always @*
begin
	// Compare drive on bit 3 only while it is the fifth compare
	a_timer    = timer_drive;
	a_timer[3] = timer_drive[3] & ~sel_capture;
	// Timer wins over the latch; bit 7 shares this path
	pa_out  = (a_timer & timer_level) | (~a_timer & a_latch);
	pa_oe_n = ~(first_port_dir_bits | a_timer);
	if (expanded_mode)
	begin
		pb_out       = high_address;
		pb_oe_n      = 8'h00;
		pb_pullup_en = 1'b0;
		pc_out       = bus_data_out;
		pc_oe_n      = {8{~bus_data_drive}};
		pc_pullup_en = 1'b0;
	end
	else
	begin
		pb_out       = b_latch;
		pb_oe_n      = ~second_port_dir_bits;
		pb_pullup_en = pullup_sel[`PIO_PU_B_BIT];
		pc_out       = third_port_data;
		pc_oe_n      = ~third_port_dir_bits;
		pc_pullup_en = pullup_sel[`PIO_PU_C_BIT];
	end
	// In slave mode the SPI block owns the pin
	pd5_oe_n = ~(spi_master & d_dir[5]);
end

// Pin level feeds the capture even when software drives it
assign fourth_input_capture = pa_sync[3] & sel_capture;
assign pulse_accum_input    = pa_sync[7];
assign spi_error_detect     = spi_master & ~d_dir[5] & pd5_sync;
assign bus_data_in          = pc_sync;

// ****************************************
// APB read path
// ****************************************
// Loaded in setup so data and error stand through the access cycle
always @(posedge pclk or negedge presetn)
begin
	if (!presetn)
	begin
		prdata  <= 32'h00000000;
		pslverr <= 1'b0;
	end
	else if (setup_phase)
	begin
		prdata  <= 32'h00000000;
		pslverr <= 1'b0;
		case (idx)
		`PIO_IDX_A_DATA:
			prdata[7:0] <= port_view(first_port_dir_bits, a_latch,
				pa_sync);
		`PIO_IDX_A_DIR:  prdata[7:0] <= first_port_dir_bits;
		`PIO_IDX_B_DIR:  prdata[7:0] <= second_port_dir_bits;
		`PIO_IDX_B_DATA:
			if (expanded_mode)
				pslverr <= 1'b1;
			else
				prdata[7:0] <= port_view(second_port_dir_bits, b_latch,
					pb_sync);
		`PIO_IDX_C_DATA:
			if (expanded_mode)
				pslverr <= 1'b1;
			else
				prdata[7:0] <= port_view(third_port_dir_bits,
					third_port_data, pc_sync);
		`PIO_IDX_C_DIR:  prdata[7:0] <= third_port_dir_bits;
		`PIO_IDX_D_DIR:  prdata[5:0] <= d_dir;
		`PIO_IDX_PA_CTRL: prdata[`PIO_SEL_BIT] <= sel_capture;
		`PIO_IDX_CAPCMP: prdata[15:0] <= capcmp;
		`PIO_IDX_PULLUP: prdata[1:0] <= pullup_sel;
		`PIO_IDX_STATUS: prdata[7:0] <= {1'b0, expanded_mode,
			lines_available};
		default: pslverr <= 1'b1;
		endcase
	end
end

endmodule // pio_ports

/* pio_ports_chk.sv */
// Checker for pio_ports: pad muxing, sync paths, refused accesses.
// Assumes it is bound to pio_ports and sees only its ports.
`timescale 1ns/1ns
module pio_ports_chk
(
	// Clock, reset, APB
	input wire        pclk,
	input wire        presetn,
	input wire        psel,
	input wire        penable,
	input wire [7:0]  paddr,
	input wire        pslverr,
	// Pads
	input wire [7:0]  pa_in,
	input wire [7:0]  pb_out,
	input wire [7:0]  pb_oe_n,
	input wire [7:0]  pc_oe_n,
	input wire        pd5_oe_n,
	// Side logic
	input wire        capture_load,
	input wire        capture_compare_select,
	input wire [15:0] shared_capture_compare_reg,
	input wire        fourth_input_capture,
	input wire        pulse_accum_input,
	input wire        spi_master,
	input wire [5:0]  fourth_port_dir_bits,
	input wire [7:0]  high_address,
	input wire        bus_data_drive,
	input wire        expanded_mode,
	input wire [5:0]  lines_available
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	// ****************************************
	// Properties
	// ****************************************
	// Sync flops hold stale levels for two edges after reset
	reg [1:0] up;
	always @(posedge pclk or negedge presetn)
		if (!presetn)
			up <= 2'h0;
		else if (up != 2'h3)
			up <= up + 2'h1;
	sequence s_gone;
		psel && !penable && expanded_mode && paddr[7:3] == 5'h02;
	endsequence
	a_lines_mode: assert property (
		lines_available == (expanded_mode ? 6'h2E : 6'h3E))
		else $error("line count");
	a_b_address: assert property (
		expanded_mode |-> pb_oe_n == 8'h00 && pb_out == high_address)
		else $error("port b address");
	a_c_bus: assert property (
		expanded_mode |-> pc_oe_n == {8{!bus_data_drive}})
		else $error("port c bus");
	a_pd5_dir: assert property (
		pd5_oe_n == !(spi_master && fourth_port_dir_bits[5]))
		else $error("pd5 direction");
	a_accum_feed: assert property (
		up == 2'h3 |-> pulse_accum_input == $past(pa_in[7], 2))
		else $error("accum input");
	a_capture_gate: assert property (
		up == 2'h3 |-> fourth_input_capture ==
		(capture_compare_select && $past(pa_in[3], 2)))
		else $error("capture gate");
	a_capcmp_frozen: assert property (
		$past(capture_compare_select) && !$past(capture_load)
		|-> $stable(shared_capture_compare_reg))
		else $error("capcmp changed");
	a_gone_err: assert property (
		s_gone ##1 penable |-> pslverr)
		else $error("unmapped data reg");
endmodule // pio_ports_chk
bind pio_ports pio_ports_chk i_chk (.pclk, .presetn, .psel, .penable, .paddr,
	.pslverr, .pa_in, .pb_out, .pb_oe_n, .pc_oe_n, .pd5_oe_n, .capture_load,
	.capture_compare_select, .shared_capture_compare_reg,
	.fourth_input_capture, .pulse_accum_input, .spi_master,
	.fourth_port_dir_bits, .high_address, .bus_data_drive, .expanded_mode,
	.lines_available);

/* pio_pins.sv */
// Pad model: each pad follows its driver, else the outside level.
// Assumes the bench gives the outside level of released pads.
`timescale 1ns/1ns
module pio_pins
(
	// Port side
	input  wire [7:0] drv,
	input  wire [7:0] oe_n,
	// Outside
	input  wire [7:0] ext,
	output wire [7:0] pad
);
	assign pad = (drv & ~oe_n) | (ext & oe_n);
endmodule // pio_pins

/* tb_pio_ports.sv */
// Bench for pio_ports: APB register sequences, pad and mode checks.
// Assumes pio_pins for the pads and the checker bound in.
`timescale 1ns/1ns
`include "pio_defs.vh"
module tb_pio_ports;
	reg         pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
	reg         pwrite = 1'b0, strap_expanded = 1'b0, pd5_in = 1'b0;
	reg         capture_load = 1'b0, spi_master = 1'b0, bus_data_drive = 1'b0;
	reg  [7:0]  paddr = 8'h00, ext = 8'h5A;
	reg  [31:0] pwdata = 32'h0;
	reg  [15:0] capture_value = 16'h0;
	reg  [7:0]  timer_drive = 8'h00, timer_level = 8'h00;
	wire [31:0] prdata;
	wire [15:0] shared_capture_compare_reg;
	wire [7:0]  pa_in, pa_out, pa_oe_n, pb_in, pb_out, pb_oe_n;
	wire [7:0]  pc_in, pc_out, pc_oe_n, bus_data_in;
	wire [5:0]  fourth_port_dir_bits, lines_available;
	wire        pready, pslverr, pb_pullup_en, pc_pullup_en, pd5_oe_n;
	wire        capture_compare_select, fourth_input_capture, expanded_mode;
	wire        pulse_accum_input, spi_error_detect;
	integer     bad_count = 0;
	integer     samples_checked = 0;
	pio_ports i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
		.pwdata, .pstrb(4'hF), .pready, .prdata, .pslverr, .strap_expanded,
		.pa_in, .pa_out, .pa_oe_n, .pb_in, .pb_out, .pb_oe_n, .pb_pullup_en,
		.pc_in, .pc_out, .pc_oe_n, .pc_pullup_en, .pd5_in, .pd5_oe_n,
		.timer_drive, .timer_level, .capture_load,
		.capture_value, .capture_compare_select, .shared_capture_compare_reg,
		.fourth_input_capture, .pulse_accum_input, .spi_master,
		.spi_error_detect, .fourth_port_dir_bits, .high_address(8'hC5),
		.bus_data_out(8'h96), .bus_data_drive, .bus_data_in, .expanded_mode,
		.lines_available);
	pio_pins i_pa (.drv(pa_out), .oe_n(pa_oe_n), .ext(ext), .pad(pa_in));
	pio_pins i_pb (.drv(pb_out), .oe_n(pb_oe_n), .ext(ext), .pad(pb_in));
	pio_pins i_pc (.drv(pc_out), .oe_n(pc_oe_n), .ext(ext), .pad(pc_in));
	initial
		forever #5 pclk = ~pclk;
	// ****************************************
	// Tasks
	// ****************************************
	task complete_run;
	begin
		$display("checked %0d, wrong %0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	end
	endtask
	task chk(input [31:0] s, input [31:0] x);
	begin
		samples_checked = samples_checked + 1;
		if (s !== x)
		begin
			bad_count = bad_count + 1;
			$display("wrong value at %0t: got %h want %h", $time, s, x);
		end
	end
	endtask
	// Master waits for pready; a hang ends the run
	task apb(input w, input [5:0] i, input [31:0] d, input [31:0] x, input e);
		integer n;
	begin
		n = 0;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= {i, 2'b00};
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		// Ready looked at mid-cycle, so the next rising edge samples it high
		@(negedge pclk);
		while (pready !== 1'b1 && n < 16)
		begin
			@(negedge pclk);
			n = n + 1;
		end
		@(posedge pclk);
		psel <= 1'b0;
		penable <= 1'b0;
		if (!w)
			chk(prdata, x);
		chk(pslverr, e);
		if (n == 16)
		begin
			bad_count = bad_count + 1;
			complete_run;
		end
	end
	endtask
	task wr(input [5:0] i, input [31:0] d);
		apb(1'b1, i, d, 32'h0, 1'b0);
	endtask
	task rd(input [5:0] i, input [31:0] x);
		apb(1'b0, i, 32'h0, x, 1'b0);
	endtask
	task rst;
	begin
		@(posedge pclk);
		presetn <= 1'b0;
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		repeat (4) @(posedge pclk);
	end
	endtask
	task settle;
	begin
		repeat (3) @(posedge pclk);
		#1;
	end
	endtask
	// ****************************************
	// Sequence
	// ****************************************
	initial
	begin
		rst;
		rd(`PIO_IDX_A_DIR, 32'h00);
		rd(`PIO_IDX_B_DIR, 32'h00);
		rd(`PIO_IDX_C_DIR, 32'h00);
		wr(`PIO_IDX_C_DIR, 32'hFF);
		rd(`PIO_IDX_C_DATA, 32'h00);
		rd(`PIO_IDX_STATUS, 32'h3E);
		apb(1'b0, 6'h03, 32'h0, 32'h0, 1'b1);
		wr(`PIO_IDX_A_DIR, 32'hFF);
		rd(`PIO_IDX_A_DATA, 32'h5A);
		ext <= 8'hA5;
		wr(`PIO_IDX_A_DIR, 32'h0F);
		wr(`PIO_IDX_A_DATA, 32'h3C);
		settle;
		chk(pa_oe_n, 8'hF0);
		rd(`PIO_IDX_A_DATA, 32'hAC);
		wr(`PIO_IDX_A_DIR, 32'h88);
		wr(`PIO_IDX_A_DATA, 32'h88);
		timer_drive <= 8'h88;
		timer_level <= 8'h80;
		settle;
		chk(pa_out, 8'h80);
		chk(fourth_input_capture, 1'b0);
		wr(`PIO_IDX_PA_CTRL, 32'h04);
		settle;
		chk(pa_out, 8'h88);
		chk({capture_compare_select, fourth_input_capture}, 2'h3);
		chk(pulse_accum_input, 1'b1);
		wr(`PIO_IDX_A_DATA, 32'h00);
		timer_drive <= 8'h00;
		settle;
		chk({fourth_input_capture, pulse_accum_input}, 2'h0);
		wr(`PIO_IDX_CAPCMP, 32'h1234);
		rd(`PIO_IDX_CAPCMP, 32'hFFFF);
		@(posedge pclk);
		capture_load <= 1'b1;
		capture_value <= 16'h0C3A;
		@(posedge pclk);
		capture_load <= 1'b0;
		rd(`PIO_IDX_CAPCMP, 32'h0C3A);
		spi_master <= 1'b1;
		pd5_in <= 1'b1;
		wr(`PIO_IDX_D_DIR, 32'hFF);
		rd(`PIO_IDX_D_DIR, 32'h3F);
		chk(pd5_oe_n, 1'b0);
		wr(`PIO_IDX_D_DIR, 32'h00);
		settle;
		chk({pd5_oe_n, spi_error_detect}, 2'h3);
		wr(`PIO_IDX_PULLUP, 32'h03);
		strap_expanded <= 1'b1;
		settle;
		chk({pb_pullup_en, pc_pullup_en}, 2'h3);
		rst;
		rd(`PIO_IDX_STATUS, 32'h6E);
		apb(1'b0, `PIO_IDX_B_DATA, 32'h0, 32'h0, 1'b1);
		apb(1'b1, `PIO_IDX_C_DATA, 32'h77, 32'h0, 1'b1);
		bus_data_drive <= 1'b1;
		settle;
		chk({pb_oe_n, pb_out, pb_pullup_en}, 17'h0018A);
		chk({pc_oe_n, pc_out, bus_data_in}, 24'h009696);
		complete_run;
	end
endmodule // tb_pio_ports
